// >>> psr_pkg.sv
/*
  Package for the link state report and event interrupt enable registers.
  Assumes a 16-bit management register port with one-cycle strobes and a
  read answer one cycle later; register addresses are management indices.
*/
// Summary of operation
// [R1] Speed field bits 15:14, encoded 10/100/1000
// [R2] Bit 13 reports full or half duplex
// [R3] Bit 12 page received, latched, read clears
// [R4] Bit 11 negotiation complete or disabled
// [R5] Bit 10 shows present link state
// [R6] Bit 1 polarity, bit 6 crossover
// [R7] Bit 5 wirespeed downgrade indication
// [R8] Bit 0 jabber condition present
// [R9] Bit 3 transmit pause, valid when resolved
// [R10] Bit 2 receive pause, valid when resolved
// [R11] Forced mode returns zero pause bits
// [R12] Negotiation error enable, bit 15, reset zero
// [R13] Enable bit 14 gates speed change
// [R14] Enable bit 13 gates duplex change
// [R15] Enable bit 12 gates page received
// [R16] Enable bit 11 gates link failure
// [R17] Enable bit 10 gates link established
// [R18] Enable bit 6 gates wake packet
// [R19] Enable bit 5 gates wirespeed downgrade
// [R20] Enable bit 1 gates polarity change
// [R21] Enable bit 0 gates jabber
// [R22] Events latch in flags, read clears
// [R23] Reserved bits zero, status writes ignored
// [R24] Request only when flag and enable set
package psr_pkg;

  // ==========================================================================
  // Register map
  localparam logic [4:0]  ADDR_LINK_STATE_REPORT = 5'h11;
  localparam logic [4:0]  ADDR_EVENT_IRQ_ENABLES = 5'h12;
  localparam logic [4:0]  ADDR_EVENT_IRQ_FLAGS   = 5'h13;

  localparam logic [15:0] RST_EVENT_IRQ_ENABLES  = 16'h0000;
  localparam logic [15:0] RST_EVENT_IRQ_FLAGS    = 16'h0000;
  // Bits 9:7 and 4:2 hold no event; they store nothing and read zero
  localparam logic [15:0] IRQ_IMPL_MASK          = 16'hFC63;

  // ==========================================================================
  // Status field positions
  localparam int POS_SPEED_LO  = 14;
  localparam int POS_DUPLEX    = 13;
  localparam int POS_PAGE_RX   = 12;
  localparam int POS_RESOLVED  = 11;
  localparam int POS_LINK      = 10;
  localparam int POS_CROSSOVER = 6;
  localparam int POS_DOWNSHIFT = 5;
  localparam int POS_TX_PAUSE  = 3;
  localparam int POS_RX_PAUSE  = 2;
  localparam int POS_POLARITY  = 1;
  localparam int POS_JABBER    = 0;

  // Speed encodings
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [1:0] speed;
    logic       full_duplex;
    logic       an_enabled;
    logic       an_complete;
    logic       link_up;
    logic       crossover;
    logic       downshift;
    logic       tx_pause;
    logic       rx_pause;
    logic       polarity_rev;
    logic       jabber;
  } psr_line_s;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } psr_bus_s;

endpackage : psr_pkg

// >>> psr_regs.sv
/*
  Link state report, event interrupt enables and event interrupt flags.
  Assumes line and event inputs come from logic on clk_i (no synchronisers)
  and that the register master obeys one-cycle strobes.
*/
// Decided for this implementation: the plain strobed port.
module psr_regs (
  input  wire logic             clk_i,       // 20 MHz clock
  input  wire logic             rst_n_i,     // async reset, active low
  input  wire logic             ce_i,        // clock enable, freezes state
  input  wire psr_pkg::psr_bus_s bus_i,      // register request
  output logic [15:0]           rdata_o,     // read data, cycle after rd
  input  wire psr_pkg::psr_line_s line_i,    // resolved line state
  input  wire logic             page_rx_i,   // page received pulse
  input  wire logic [15:0]      event_i,     // event pulses, enable layout
  output logic                  irq_o        // flagged and enabled event
);

  // ==========================================================================
  // Decode
  wire rd_status = bus_i.rd && bus_i.addr == psr_pkg::ADDR_LINK_STATE_REPORT;
  wire wr_enab   = bus_i.wr && bus_i.addr == psr_pkg::ADDR_EVENT_IRQ_ENABLES;
  wire rd_enab   = bus_i.rd && bus_i.addr == psr_pkg::ADDR_EVENT_IRQ_ENABLES;
  wire rd_flags  = bus_i.rd && bus_i.addr == psr_pkg::ADDR_EVENT_IRQ_FLAGS;

  default clocking dflt_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==========================================================================
  // State
  logic        page_q, page_d;
  logic [15:0] enab_q, enab_d;
  logic [15:0] flag_q, flag_d;
  logic [15:0] rdata_q, rdata_d;

  // Page event raised in the read cycle survives the clear
  assign page_d = page_rx_i | (page_q & ~rd_status);                          // R3
  assign enab_d = wr_enab ? (bus_i.wdata & psr_pkg::IRQ_IMPL_MASK) : enab_q;  // R12
  assign flag_d = (event_i & psr_pkg::IRQ_IMPL_MASK) |
                  (flag_q & ~(rd_flags ? 16'hFFFF : 16'h0000));               // R22

  // ==========================================================================
  // Status word
  wire pause_ok = line_i.an_enabled;                                          // R11
  wire resolved = ~line_i.an_enabled | line_i.an_complete;                    // R4
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;                                                        // R23
    status[psr_pkg::POS_SPEED_LO +: 2] = line_i.speed;                        // R1
    status[psr_pkg::POS_DUPLEX]    = line_i.full_duplex;                      // R2
    status[psr_pkg::POS_PAGE_RX]   = page_q;                                  // R3
    status[psr_pkg::POS_RESOLVED]  = resolved;                                // R4
    status[psr_pkg::POS_LINK]      = line_i.link_up;                          // R5
    status[psr_pkg::POS_CROSSOVER] = line_i.crossover;                        // R6
    status[psr_pkg::POS_POLARITY]  = line_i.polarity_rev;                     // R6
    status[psr_pkg::POS_DOWNSHIFT] = line_i.downshift;                        // R7
    status[psr_pkg::POS_JABBER]    = line_i.jabber;                           // R8
    status[psr_pkg::POS_TX_PAUSE]  = pause_ok & line_i.tx_pause;              // R9
    status[psr_pkg::POS_RX_PAUSE]  = pause_ok & line_i.rx_pause;              // R10
  end

  // Writes to the status index and unmapped reads fall through to zero
  assign rdata_d = rd_status ? status :                                       // R23
                   rd_enab   ? enab_q :
                   rd_flags  ? flag_q : 16'h0000;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_q  <= 1'b0;
      enab_q  <= psr_pkg::RST_EVENT_IRQ_ENABLES;
      flag_q  <= psr_pkg::RST_EVENT_IRQ_FLAGS;
      rdata_q <= 16'h0000;
    end else if (ce_i) begin
      page_q  <= page_d;
      enab_q  <= enab_d;
      flag_q  <= flag_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  // Enables gate only the request, so a disabled flag stays recorded
  assign irq_o = |(flag_q & enab_q);                                          // R24

  // ==========================================================================
  // Checks
  AST_PAGE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // R3
    ce_i && page_rx_i |=> page_q) else $error("page flag not set");
  AST_PAGE_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)   // R3
    ce_i && rd_status && !page_rx_i |=> !page_q) else $error("page flag not cleared");
  AST_RD_STATUS: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // R1
    ce_i && rd_status |=> rdata_o == $past(status)) else $error("status read wrong");
  AST_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i)       // R23
    ce_i && rd_status |=> (rdata_o & 16'h0390) == 16'h0000) else $error("reserved bits set");
  AST_FORCED: assert property (@(posedge clk_i) disable iff (!rst_n_i)     // R11
    !line_i.an_enabled |-> status[3:2] == 2'h0) else $error("pause bits in forced mode");
  AST_RESOLVED: assert property (@(posedge clk_i) disable iff (!rst_n_i)   // R4
    status[11] == (!line_i.an_enabled || line_i.an_complete)) else $error("resolved bit wrong");
  AST_ENAB_WR: assert property (@(posedge clk_i) disable iff (!rst_n_i)    // R13
    ce_i && wr_enab ##1 ce_i && bus_i.rd && bus_i.addr == psr_pkg::ADDR_EVENT_IRQ_ENABLES && !wr_enab
    |=> rdata_o == ($past(bus_i.wdata, 2) & psr_pkg::IRQ_IMPL_MASK)) else $error("enable readback");
  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)   // R22
    ce_i && event_i[0] |=> flag_q[0]) else $error("event not latched");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)        // R24
    irq_o == |(flag_q & enab_q)) else $error("irq gating wrong");
  AST_FLAG_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // R24
    ce_i && flag_q[1] && !rd_flags |=> flag_q[1]) else $error("flag lost");
  COV_PAGE: cover property (@(posedge clk_i) page_rx_i ##1 rd_status);
  COV_IRQ: cover property (@(posedge clk_i) !irq_o ##1 irq_o);
  COV_SAME: cover property (@(posedge clk_i) rd_flags && event_i[0]);
  COV_CE_LOW: cover property (@(posedge clk_i) !ce_i ##1 ce_i);
  COV_FORCED: cover property (@(posedge clk_i) rd_status && !line_i.an_enabled);

  // ==========================================================================
  // Status field checks, one per field of a status read
  AST_SPEED_RD: assert property ( // R1
    ce_i && rd_status |=> rdata_o[15:14] == $past(line_i.speed)
  ) else $error("speed field read wrong");

  AST_DUPLEX_RD: assert property ( // R2
    ce_i && rd_status |=> rdata_o[13] == $past(line_i.full_duplex)
  ) else $error("duplex bit read wrong");

  AST_PAGE_RD: assert property ( // R3
    ce_i && rd_status |=> rdata_o[12] == $past(page_q)
  ) else $error("page bit read wrong");

  AST_RESOLVED_RD: assert property ( // R4
    ce_i && rd_status |=> rdata_o[11] == (!$past(line_i.an_enabled) || $past(line_i.an_complete))
  ) else $error("resolved bit read wrong");

  AST_LINK_RD: assert property ( // R5
    ce_i && rd_status |=> rdata_o[10] == $past(line_i.link_up)
  ) else $error("link bit read wrong");

  AST_XOVER_RD: assert property ( // R6
    ce_i && rd_status |=> rdata_o[6] == $past(line_i.crossover)
  ) else $error("crossover bit read wrong");

  AST_POL_RD: assert property ( // R6
    ce_i && rd_status |=> rdata_o[1] == $past(line_i.polarity_rev)
  ) else $error("polarity bit read wrong");

  AST_DOWN_RD: assert property ( // R7
    ce_i && rd_status |=> rdata_o[5] == $past(line_i.downshift)
  ) else $error("downgrade bit read wrong");

  AST_JAB_RD: assert property ( // R8
    ce_i && rd_status |=> rdata_o[0] == $past(line_i.jabber)
  ) else $error("jabber bit read wrong");

  AST_TXP_RD: assert property ( // R9
    ce_i && rd_status |=> rdata_o[3] == ($past(line_i.an_enabled) && $past(line_i.tx_pause))
  ) else $error("transmit pause read wrong");

  AST_RXP_RD: assert property ( // R10
    ce_i && rd_status |=> rdata_o[2] == ($past(line_i.an_enabled) && $past(line_i.rx_pause))
  ) else $error("receive pause read wrong");

  AST_FORCED_RD: assert property ( // R11
    ce_i && rd_status && !line_i.an_enabled |=> rdata_o[3:2] == 2'h0
  ) else $error("pause bits read in forced mode");

  AST_RSVD_HI: assert property ( // R23
    ce_i && rd_status |=> rdata_o[9:7] == 3'h0
  ) else $error("upper reserved bits set");

  AST_RSVD_LO: assert property ( // R23
    ce_i && rd_status |=> rdata_o[4] == 1'b0
  ) else $error("lower reserved bit set");

  AST_NEG_OPEN: assert property ( // R4
    line_i.an_enabled && !line_i.an_complete |-> !status[11]
  ) else $error("resolved while negotiating");

  AST_LINK_LIVE: assert property ( // R5
    status[10] == line_i.link_up
  ) else $error("link bit not live");

  AST_SPEED_LIVE: assert property ( // R1
    status[15:14] == line_i.speed
  ) else $error("speed field not live");

  AST_DUPLEX_LIVE: assert property ( // R2
    status[13] == line_i.full_duplex
  ) else $error("duplex bit not live");

  AST_JAB_LIVE: assert property ( // R8
    status[0] == line_i.jabber
  ) else $error("jabber bit not live");

  // ==========================================================================
  // Enable register checks, one per implemented enable
  AST_ENAB_AN: assert property ( // R12
    ce_i && wr_enab |=> enab_q[15] == $past(bus_i.wdata[15])
  ) else $error("enable bit 15 not written");

  AST_ENAB_SPEED: assert property ( // R13
    ce_i && wr_enab |=> enab_q[14] == $past(bus_i.wdata[14])
  ) else $error("enable bit 14 not written");

  AST_ENAB_DUPLEX: assert property ( // R14
    ce_i && wr_enab |=> enab_q[13] == $past(bus_i.wdata[13])
  ) else $error("enable bit 13 not written");

  AST_ENAB_PAGE: assert property ( // R15
    ce_i && wr_enab |=> enab_q[12] == $past(bus_i.wdata[12])
  ) else $error("enable bit 12 not written");

  AST_ENAB_LFAIL: assert property ( // R16
    ce_i && wr_enab |=> enab_q[11] == $past(bus_i.wdata[11])
  ) else $error("enable bit 11 not written");

  AST_ENAB_LUP: assert property ( // R17
    ce_i && wr_enab |=> enab_q[10] == $past(bus_i.wdata[10])
  ) else $error("enable bit 10 not written");

  AST_ENAB_WAKE: assert property ( // R18
    ce_i && wr_enab |=> enab_q[6] == $past(bus_i.wdata[6])
  ) else $error("enable bit 6 not written");

  AST_ENAB_DOWN: assert property ( // R19
    ce_i && wr_enab |=> enab_q[5] == $past(bus_i.wdata[5])
  ) else $error("enable bit 5 not written");

  AST_ENAB_POL: assert property ( // R20
    ce_i && wr_enab |=> enab_q[1] == $past(bus_i.wdata[1])
  ) else $error("enable bit 1 not written");

  AST_ENAB_JAB: assert property ( // R21
    ce_i && wr_enab |=> enab_q[0] == $past(bus_i.wdata[0])
  ) else $error("enable bit 0 not written");

  AST_ENAB_RSVD: assert property ( // R12
    (enab_q & ~psr_pkg::IRQ_IMPL_MASK) == 16'h0000
  ) else $error("reserved enable stored");

  AST_ENAB_HOLD: assert property ( // R12
    ce_i && !wr_enab |=> enab_q == $past(enab_q)
  ) else $error("enables changed without write");

  AST_ENAB_RD: assert property ( // R12
    ce_i && rd_enab |=> rdata_o == $past(enab_q)
  ) else $error("enable read wrong");

  AST_STATUS_WR: assert property ( // R23
    ce_i && bus_i.wr && bus_i.addr == psr_pkg::ADDR_LINK_STATE_REPORT |=> enab_q == $past(enab_q)
  ) else $error("status write leaked");

  // ==========================================================================
  // Event flag checks; a read clears but a same-cycle event wins
  AST_FLAG_SET_1: assert property ( // R22
    ce_i && event_i[1] |=> flag_q[1]
  ) else $error("event 1 not latched");

  AST_FLAG_SET_5: assert property ( // R22
    ce_i && event_i[5] |=> flag_q[5]
  ) else $error("event 5 not latched");

  AST_FLAG_SET_6: assert property ( // R22
    ce_i && event_i[6] |=> flag_q[6]
  ) else $error("event 6 not latched");

  AST_FLAG_SET_10: assert property ( // R22
    ce_i && event_i[10] |=> flag_q[10]
  ) else $error("event 10 not latched");

  AST_FLAG_SET_11: assert property ( // R22
    ce_i && event_i[11] |=> flag_q[11]
  ) else $error("event 11 not latched");

  AST_FLAG_SET_12: assert property ( // R22
    ce_i && event_i[12] |=> flag_q[12]
  ) else $error("event 12 not latched");

  AST_FLAG_SET_13: assert property ( // R22
    ce_i && event_i[13] |=> flag_q[13]
  ) else $error("event 13 not latched");

  AST_FLAG_SET_14: assert property ( // R22
    ce_i && event_i[14] |=> flag_q[14]
  ) else $error("event 14 not latched");

  AST_FLAG_SET_15: assert property ( // R22
    ce_i && event_i[15] |=> flag_q[15]
  ) else $error("event 15 not latched");

  AST_FLAG_CLR: assert property ( // R22
    ce_i && rd_flags |=> flag_q == ($past(event_i) & psr_pkg::IRQ_IMPL_MASK)
  ) else $error("flags not cleared by read");

  AST_FLAG_RSVD: assert property ( // R22
    (flag_q & ~psr_pkg::IRQ_IMPL_MASK) == 16'h0000
  ) else $error("reserved flag stored");

  AST_FLAG_KEEP_ALL: assert property ( // R24
    ce_i && !rd_flags |=> (flag_q & $past(flag_q)) == $past(flag_q)
  ) else $error("flag lost without read");

  AST_FLAG_QUIET: assert property ( // R22
    ce_i && flag_q == 16'h0000 && event_i == 16'h0000 |=> flag_q == 16'h0000
  ) else $error("flag set without event");

  AST_FLAG_RD: assert property ( // R22
    ce_i && rd_flags |=> rdata_o == $past(flag_q)
  ) else $error("flag read wrong");

  // ==========================================================================
  // Page flag, read data and interrupt request
  AST_PAGE_KEEP: assert property ( // R3
    ce_i && page_q && !rd_status |=> page_q
  ) else $error("page flag lost");

  AST_PAGE_QUIET: assert property ( // R3
    ce_i && !page_q && !page_rx_i |=> !page_q
  ) else $error("page flag set without page");

  AST_STATUS_WR_PAGE: assert property ( // R23
    ce_i && bus_i.wr && !bus_i.rd && page_q |=> page_q
  ) else $error("write cleared page flag");

  AST_RDATA_IDLE: assert property ( // R23
    ce_i && !bus_i.rd |=> rdata_o == 16'h0000
  ) else $error("read data without read");

  AST_UNMAPPED: assert property ( // R23
    ce_i && bus_i.rd && !rd_status && !rd_enab && !rd_flags |=> rdata_o == 16'h0000
  ) else $error("unmapped read not zero");

  AST_IRQ_OFF: assert property ( // R24
    enab_q == 16'h0000 |-> !irq_o
  ) else $error("request with no enable");

  AST_IRQ_EVENT: assert property ( // R24
    ce_i && enab_q[0] && event_i[0] && !wr_enab |=> irq_o
  ) else $error("enabled event gave no request");

  AST_IRQ_MASKED: assert property ( // R24
    ce_i && wr_enab && bus_i.wdata == 16'h0000 |=> !irq_o
  ) else $error("request after enables cleared");

  // ==========================================================================
  // Clock enable and reset; reset checks must run while reset is held
  AST_ENAB_FROZEN: assert property ( // R12
    !ce_i |=> enab_q == $past(enab_q)
  ) else $error("enables moved while frozen");

  AST_FLAG_FROZEN: assert property ( // R22
    !ce_i |=> flag_q == $past(flag_q)
  ) else $error("flags moved while frozen");

  AST_PAGE_FROZEN: assert property ( // R3
    !ce_i |=> page_q == $past(page_q)
  ) else $error("page flag moved while frozen");

  AST_RST_ENAB: assert property (disable iff (1'b0) // R12
    !rst_n_i |-> enab_q == psr_pkg::RST_EVENT_IRQ_ENABLES
  ) else $error("enables not reset");

  AST_RST_FLAG: assert property (disable iff (1'b0) // R22
    !rst_n_i |-> flag_q == psr_pkg::RST_EVENT_IRQ_FLAGS
  ) else $error("flags not reset");

  AST_RST_PAGE: assert property (disable iff (1'b0) // R3
    !rst_n_i |-> !page_q
  ) else $error("page flag not reset");

  AST_RST_IRQ: assert property (disable iff (1'b0) // R24
    !rst_n_i |-> !irq_o
  ) else $error("request during reset");

  AST_RST_RDATA: assert property (disable iff (1'b0) // R23
    !rst_n_i |-> rdata_o == 16'h0000
  ) else $error("read data during reset");

endmodule // psr_regs

// >>> psr_regs_tb.sv
/*
  Self-checking bench for psr_regs: status, enables and flags.
  Drops ce_i once and resets once mid-run; strobes leave a gap after each.
*/
module psr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i, rst_n_i, ce_i, page_rx_i, irq_o;
  logic [15:0]        event_i, rdata_o, got, ev, d;
  logic [31:0]        seed;
  int                 errors, compares;
  psr_pkg::psr_bus_s  bus_i;
  psr_pkg::psr_line_s line_i;
  psr_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o),
                  .line_i(line_i), .page_rx_i(page_rx_i), .event_i(event_i), .irq_o(irq_o));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Pause bits read zero in forced mode
  function automatic logic [15:0] stat(psr_pkg::psr_line_s l, logic pg);
    return {l.speed, l.full_duplex, pg, !l.an_enabled | l.an_complete, l.link_up, 3'h0, l.crossover,
            l.downshift, 1'b0, l.tx_pause & l.an_enabled, l.rx_pause & l.an_enabled, l.polarity_rev, l.jabber};
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(logic e);
    compares++;
    if (irq_o !== e) begin
      errors++;
      $display("wrong value at %0t: irq %b expected %b", $time, irq_o, e);
    end
  endtask
  // Each access leaves one idle edge so no strobe is driven twice in one step
  task automatic acc(logic [4:0] a, logic [15:0] wd, logic w);
    bus_i <= '{addr: a, wdata: wd, wr: w, rd: !w};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
    bus_i.rd <= 1'b0;
    #1 got = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Clock, reset and sequence
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    {rst_n_i, page_rx_i, event_i, line_i, bus_i, errors, compares} = '0;
    ce_i = 1'b1;
    seed = 32'hDE38;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    acc(5'h12, 16'h0000, 1'b0); chk(got, psr_pkg::RST_EVENT_IRQ_ENABLES);
    acc(5'h13, 16'h0000, 1'b0); chk(got, 16'h0000);
    acc(5'h05, 16'h0000, 1'b0); chk(got, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      line_i <= {2'(seed[17:16] % 3), seed[9:0]};
      acc(5'h11, seed[31:16], 1'b1);
      acc(5'h11, 16'h0000, 1'b0); chk(got, stat(line_i, 1'b0));
      d = (i == 0) ? 16'hFFFF : seed[31:16];
      acc(5'h12, d, 1'b1);
      acc(5'h12, 16'h0000, 1'b0); chk(got, d & psr_pkg::IRQ_IMPL_MASK);
    end
    page_rx_i <= 1'b1;
    @(posedge clk_i);
    page_rx_i <= 1'b0;
    @(posedge clk_i);
    acc(5'h11, 16'h0000, 1'b0); chk(got, stat(line_i, 1'b1));
    acc(5'h11, 16'h0000, 1'b0); chk(got, stat(line_i, 1'b0));
    acc(5'h12, 16'h0000, 1'b1);
    ev = (xs(seed) & psr_pkg::IRQ_IMPL_MASK) | 16'h0001;
    event_i <= ev;
    @(posedge clk_i);
    event_i <= 16'h0000;
    #1 chk1(1'b0);
    acc(5'h12, ev, 1'b1); chk1(1'b1);
    acc(5'h12, 16'h0000, 1'b1); chk1(1'b0);
    acc(5'h13, 16'hFFFF, 1'b1);
    acc(5'h13, 16'h0000, 1'b0); chk(got, ev);
    acc(5'h13, 16'h0000, 1'b0); chk(got, 16'h0000);
    event_i <= 16'h0002;
    acc(5'h13, 16'h0000, 1'b0); chk(got, 16'h0000);
    event_i <= 16'h0000;
    acc(5'h13, 16'h0000, 1'b0); chk(got, 16'h0002);
    page_rx_i <= 1'b1;
    acc(5'h11, 16'h0000, 1'b0); chk(got, stat(line_i, 1'b0));
    page_rx_i <= 1'b0;
    acc(5'h11, 16'h0000, 1'b0); chk(got, stat(line_i, 1'b1));
    ce_i <= 1'b0;
    acc(5'h12, 16'hFFFF, 1'b1);
    ce_i <= 1'b1;
    acc(5'h12, 16'h0000, 1'b0); chk(got, 16'h0000);
    acc(5'h05, 16'hFFFF, 1'b1);
    acc(5'h11, 16'hFFFF, 1'b1);
    acc(5'h12, 16'h0000, 1'b0); chk(got, 16'h0000);
    acc(5'h12, 16'hFFFF, 1'b1);
    event_i <= 16'h0001;
    @(posedge clk_i);
    event_i <= 16'h0000;
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk1(1'b0);
    @(posedge clk_i);
    acc(5'h12, 16'h0000, 1'b0); chk(got, psr_pkg::RST_EVENT_IRQ_ENABLES);
    acc(5'h13, 16'h0000, 1'b0); chk(got, psr_pkg::RST_EVENT_IRQ_FLAGS);
    close_out();
  end
endmodule // psr_regs_tb
